// File: logic/ext_link_regs_defines.vh
`ifndef EXT_LINK_REGS_DEFINES_VH
`define EXT_LINK_REGS_DEFINES_VH
// register byte addresses
`define ADDR_LINK_SETUP      8'h80
`define ADDR_STATIC_FWD      8'hA0
`define ADDR_IRQ_STATUS      8'hC0
`define ADDR_IRQ_MASK        8'hC4
`define ADDR_PIN_OUT         8'hC8
// link_setup_and_status fields
`define LS_ENABLE            31
`define LS_FIVE_WIRE         30
`define LS_ERROR             27
`define LS_CREDIT_GIVEN      26
`define LS_CREDIT_HELD       25
`define LS_HDX_INIT          24
`define LS_RX_RESET          23
`define LS_SYM_HI            21
`define LS_SYM_LO            11
`define LS_TOK_HI            10
`define LS_TOK_LO            0
// static_forward_setup fields
`define SF_ENABLE            31
`define SF_CHAN_HI           4
`define SF_CHAN_LO           0
// interrupt status bits
`define IRQ_ERROR            0
`define IRQ_JUNK             1
`define IRQ_CREDIT           2
`define IRQ_WIDTH            3
// reset values
`define RST_WORD             32'h0000_0000
// bus responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10
`endif

// File: logic/external_link_control_regs.v
// Contract
// - top control bit enables or disables link
// - enable bit steers port versus link muxing
// - wire mode bit: zero two-wire, one five-wire
// - overflow or illegal token sets error flag
// - reading link register clears error flag
// - status shows credit issued to remote end
// - status shows credit held for sending
// - init clears credit, sends greeting, self-clears
// - receiver reset resyncs on next symbol
// - eleven-bit clocks between transitions within token
// - eleven-bit clocks between consecutive tokens
// - static mode forwards all traffic locally
// - five-bit field names forwarding channel end
// - unroutable packet flagged junk and discarded
`timescale 1ns/1ps
`default_nettype none
`include "ext_link_regs_defines.vh"

module external_link_control_regs #(
  parameter ADDR_W = 8
) (
  input  wire              i_clk_sys,
  input  wire              i_rst_n,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // events from link receiver and switch, same clock domain
  input  wire              i_rx_overflow,
  input  wire              i_rx_illegal_token,
  input  wire              i_rx_credit_token,
  input  wire              i_tx_credit_used_up,
  input  wire              i_credit_issued,
  input  wire              i_credit_withdrawn,
  input  wire              i_pkt_unroutable,
  input  wire              i_pkt_end,
  // link control to link logic
  output reg               o_link_enable,
  output reg               o_port_mux_link,
  output reg               o_five_wire,
  output reg               o_send_greeting,
  output reg               o_rx_resync,
  output reg  [10:0]       o_symbol_gap,
  output reg  [10:0]       o_token_gap,
  output reg               o_static_fwd,
  output reg  [4:0]        o_static_chanend,
  output reg               o_discard,
  output reg               o_irq
);

  // register state
  reg        en_q;           // link enable
  reg        five_q;         // wire mode
  reg        err_q;          // sticky error flag
  reg        cr_given_q;     // credit issued to remote
  reg        cr_held_q;      // credit held locally
  reg [10:0] sym_q;          // intra-token spacing
  reg [10:0] tok_q;          // inter-token spacing
  reg        sf_en_q;        // static forward enable
  reg [4:0]  sf_ch_q;        // static channel end
  reg        junk_q;         // current packet junk
  reg [2:0]  ist_q;          // interrupt status
  reg [2:0]  imask_q;        // interrupt mask
  // bus holding registers
  reg [ADDR_W-1:0] awaddr_q;
  reg        aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg        w_have_q;

  // merge byte lanes into a word
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // link register image, reserved bits zero
  function [31:0] link_word;
    input e;
    input f;
    input er;
    input cg;
    input ch;
    input [10:0] s;
    input [10:0] t;
    begin
      link_word = `RST_WORD;
      link_word[`LS_ENABLE] = e;
      link_word[`LS_FIVE_WIRE] = f;
      link_word[`LS_ERROR] = er;
      link_word[`LS_CREDIT_GIVEN] = cg;
      link_word[`LS_CREDIT_HELD] = ch;
      link_word[`LS_SYM_HI:`LS_SYM_LO] = s;
      link_word[`LS_TOK_HI:`LS_TOK_LO] = t;
    end
  endfunction

  // accept address and data independently, one write in flight
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire       wr_go = aw_have_q && w_have_q;          // both halves present
  wire       rd_go = s_axi_arvalid && s_axi_arready; // read taken
  wire [31:0] w_link = merge(link_word(en_q, five_q, 1'b0, 1'b0, 1'b0, sym_q, tok_q),
                             wdata_q, wstrb_q);
  wire [31:0] w_sf = merge({sf_en_q, 26'd0, sf_ch_q}, wdata_q, wstrb_q);
  wire [31:0] w_gen = merge(32'h0000_0000, wdata_q, wstrb_q);
  wire wr_link = wr_go && (awaddr_q == `ADDR_LINK_SETUP);
  wire wr_sf   = wr_go && (awaddr_q == `ADDR_STATIC_FWD);
  wire wr_ist  = wr_go && (awaddr_q == `ADDR_IRQ_STATUS);
  wire wr_imk  = wr_go && (awaddr_q == `ADDR_IRQ_MASK);
  wire wr_ok   = wr_link || wr_sf || wr_ist || wr_imk;
  wire rd_link = rd_go && (s_axi_araddr == `ADDR_LINK_SETUP);
  wire err_ev  = i_rx_overflow || i_rx_illegal_token;
  wire [2:0] ev = {i_rx_credit_token, i_pkt_unroutable, err_ev};

  // write channel capture and response
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      awaddr_q     <= {ADDR_W{1'b0}};
      aw_have_q    <= 1'b0;
      wdata_q      <= `RST_WORD;
      wstrb_q      <= 4'h0;
      w_have_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q  <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data path
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `RST_WORD;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (s_axi_araddr)
        `ADDR_LINK_SETUP: s_axi_rdata <= link_word(en_q, five_q, err_q, cr_given_q,
                                                   cr_held_q, sym_q, tok_q);
        `ADDR_STATIC_FWD: s_axi_rdata <= {sf_en_q, 26'd0, sf_ch_q};
        `ADDR_IRQ_STATUS: s_axi_rdata <= {29'd0, ist_q};
        `ADDR_IRQ_MASK:   s_axi_rdata <= {29'd0, imask_q};
        `ADDR_PIN_OUT:    s_axi_rdata <= {29'd0, junk_q, o_static_fwd, o_port_mux_link};
        default: begin
          s_axi_rdata <= `RST_WORD;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // control fields and one-cycle strobes
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q            <= 1'b0;
      five_q          <= 1'b0;
      sym_q           <= 11'd0;
      tok_q           <= 11'd0;
      sf_en_q         <= 1'b0;
      sf_ch_q         <= 5'd0;
      o_send_greeting <= 1'b0;
      o_rx_resync     <= 1'b0;
      imask_q         <= 3'd0;
    end else begin
      o_send_greeting <= wr_link && w_link[`LS_HDX_INIT];
      o_rx_resync     <= wr_link && w_link[`LS_RX_RESET];
      if (wr_link) begin
        en_q   <= w_link[`LS_ENABLE];
        five_q <= w_link[`LS_FIVE_WIRE];
        sym_q  <= w_link[`LS_SYM_HI:`LS_SYM_LO];
        tok_q  <= w_link[`LS_TOK_HI:`LS_TOK_LO];
      end
      if (wr_sf) begin
        sf_en_q <= w_sf[`SF_ENABLE];
        sf_ch_q <= w_sf[`SF_CHAN_HI:`SF_CHAN_LO];
      end
      if (wr_imk) begin
        imask_q <= w_gen[2:0];
      end
    end
  end

  // link status flags
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_q      <= 1'b0;
      cr_given_q <= 1'b0;
      cr_held_q  <= 1'b0;
      junk_q     <= 1'b0;
    end else begin
      // event wins over clear-on-read
      if (err_ev) begin
        err_q <= 1'b1;
      end else if (rd_link) begin
        err_q <= 1'b0;
      end
      // credit issued to remote
      if (i_credit_issued) begin
        cr_given_q <= 1'b1;
      end else if (i_credit_withdrawn) begin
        cr_given_q <= 1'b0;
      end
      // remote credit arrives after greeting; init clears
      if (i_rx_credit_token) begin
        cr_held_q <= 1'b1;
      end else if ((wr_link && w_link[`LS_HDX_INIT]) || i_tx_credit_used_up) begin
        cr_held_q <= 1'b0;
      end
      // junk marks rest of current packet
      if (i_pkt_unroutable && !o_static_fwd) begin
        junk_q <= 1'b1;
      end else if (i_pkt_end) begin
        junk_q <= 1'b0;
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ist_q <= 3'd0;
    end else begin
      ist_q <= ev | (ist_q & ~(wr_ist ? w_gen[2:0] : 3'd0));
    end
  end

  // registered outputs to link logic
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_link_enable    <= 1'b0;
      o_port_mux_link  <= 1'b0;
      o_five_wire      <= 1'b0;
      o_symbol_gap     <= 11'd0;
      o_token_gap      <= 11'd0;
      o_static_fwd     <= 1'b0;
      o_static_chanend <= 5'd0;
      o_discard        <= 1'b0;
      o_irq            <= 1'b0;
    end else begin
      o_link_enable    <= en_q;
      o_port_mux_link  <= en_q;
      o_five_wire      <= five_q;
      o_symbol_gap     <= sym_q;
      o_token_gap      <= tok_q;
      o_static_fwd     <= sf_en_q;
      o_static_chanend <= sf_ch_q;
      o_discard        <= junk_q || (i_pkt_unroutable && !sf_en_q);
      o_irq            <= |(ist_q & imask_q);
    end
  end

endmodule
`default_nettype wire

// File: testbench/external_link_control_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_link_regs_defines.vh"
// watches bus answers and control outputs
module external_link_control_regs_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        i_pkt_unroutable,
  input wire logic        o_link_enable,
  input wire logic        o_port_mux_link,
  input wire logic        o_five_wire,
  input wire logic [10:0] o_symbol_gap,
  input wire logic [10:0] o_token_gap,
  input wire logic        o_send_greeting,
  input wire logic        o_rx_resync,
  input wire logic        o_static_fwd,
  input wire logic        o_discard
);
  logic [7:0] ar_q; // address of the read in flight
  // hold the read address until its data returns
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) ar_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_mux_tracks_enable: assert property (o_port_mux_link == o_link_enable)
    else $error("port mux differs from link enable");
  a_enable_by_write: assert property ($changed(o_link_enable) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("enable moved without write");
  a_cfg_by_write: assert property ($changed({o_five_wire, o_symbol_gap, o_token_gap}) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("config moved without write");
  a_greet_after_write: assert property (o_send_greeting |-> s_axi_bvalid)
    else $error("greeting without write response");
  a_greet_one_cycle: assert property (o_send_greeting |=> !o_send_greeting)
    else $error("greeting longer than one cycle");
  a_resync_one_cycle: assert property (o_rx_resync |=> !o_rx_resync)
    else $error("resync longer than one cycle");
  a_junk_discards: assert property (i_pkt_unroutable && !o_static_fwd |=> o_discard)
    else $error("unroutable packet not discarded");
  a_link_rsvd_zero: assert property (s_axi_rvalid && ar_q == `ADDR_LINK_SETUP |->
    s_axi_rdata[29:28] == 2'h0 && s_axi_rdata[24:22] == 3'h0) else $error("link reserved set");
  a_static_rsvd_zero: assert property (s_axi_rvalid && ar_q == `ADDR_STATIC_FWD |->
    s_axi_rdata[30:5] == 26'h000_0000) else $error("static reserved bits set");
  c_greeting: cover property (o_send_greeting);
  c_discard: cover property (o_discard);
  c_static_read: cover property (s_axi_rvalid && ar_q == `ADDR_STATIC_FWD);
endmodule
bind external_link_control_regs external_link_control_regs_chk chk_u (
  .i_clk_sys, .i_rst_n, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .i_pkt_unroutable, .o_link_enable, .o_port_mux_link,
  .o_five_wire, .o_symbol_gap, .o_token_gap, .o_send_greeting, .o_rx_resync,
  .o_static_fwd, .o_discard);
`default_nettype wire

// File: testbench/remote_link_end.sv
`timescale 1ns/1ps
`default_nettype none
// far end of the link: answers a greeting with one credit token
module remote_link_end (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_greet,
  input  wire logic i_slow,
  output var  logic o_credit
);
  logic [4:0] wait_q; // cycles left before the credit goes out
  // count down, then pulse one credit token
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q   <= 5'h00;
      o_credit <= 1'b0;
    end else begin
      o_credit <= (wait_q == 5'h01);
      if (i_greet) wait_q <= i_slow ? 5'h14 : 5'h02;
      else if (wait_q != 5'h00) wait_q <= wait_q - 5'h01;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_external_link_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_link_regs_defines.vh"
module tb_external_link_control_regs;
  logic i_clk_sys = 0, i_rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, slow = 0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [6:0]  ev = 7'h00; // event pulses into the block
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic i_rx_credit_token, o_link_enable, o_port_mux_link, o_five_wire, o_send_greeting;
  logic o_rx_resync, o_static_fwd, o_discard, o_irq;
  logic [10:0] o_symbol_gap, o_token_gap;
  logic [4:0]  o_static_chanend;
  int err_count = 0, tests_run = 0, cyc = 0, n_greet = 0, n_sync = 0;
  external_link_control_regs dut_u (.i_clk_sys, .i_rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_rx_overflow(ev[0]),
    .i_rx_illegal_token(ev[1]), .i_rx_credit_token, .i_tx_credit_used_up(ev[2]),
    .i_credit_issued(ev[3]), .i_credit_withdrawn(ev[4]), .i_pkt_unroutable(ev[5]),
    .i_pkt_end(ev[6]), .o_link_enable, .o_port_mux_link, .o_five_wire, .o_send_greeting,
    .o_rx_resync, .o_symbol_gap, .o_token_gap, .o_static_fwd, .o_static_chanend,
    .o_discard, .o_irq);
  remote_link_end far_u (.i_clk_sys, .i_rst_n, .i_greet(o_send_greeting), .i_slow(slow),
    .o_credit(i_rx_credit_token));
  always #12.5 i_clk_sys = ~i_clk_sys;
  // count pulses and cut a hang short
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_send_greeting) n_greet++;
    if (o_rx_resync) n_sync++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one bus write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge i_clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    resp = s_axi_bresp;
  endtask
  // one bus read
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge i_clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    rd_d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic pulse(input int b, input int w);
    @(posedge i_clk_sys);
    ev[b] <= 1;
    @(posedge i_clk_sys);
    ev[b] <= 0;
    repeat (w) @(posedge i_clk_sys);
  endtask
  task automatic t_reset();
    rd(`ADDR_LINK_SETUP); chk("link rst", rd_d, `RST_WORD);
    rd(`ADDR_STATIC_FWD); chk("static rst", rd_d, `RST_WORD);
    chk("outs rst", {o_link_enable, o_five_wire, o_static_fwd, o_discard}, 0);
    $display("reset test done");
  endtask
  task automatic t_link_cfg();
    wr(`ADDR_LINK_SETUP, 32'hFFFF_FFFF, 4'hF);
    chk("bresp", resp, `RESP_OKAY);
    repeat (4) @(posedge i_clk_sys);
    chk("outs", {o_link_enable, o_port_mux_link, o_five_wire}, 3'h7);
    chk("gaps", {o_symbol_gap, o_token_gap}, 22'h3F_FFFF);
    chk("pulses", {n_greet[3:0], n_sync[3:0]}, 8'h11);
    rd(`ADDR_LINK_SETUP); chk("link rd", rd_d, 32'hC23F_FFFF);
    wr(`ADDR_LINK_SETUP, 32'h4020_0C01, 4'hF);
    rd(`ADDR_LINK_SETUP); chk("link rd2", rd_d, 32'h4220_0C01);
    chk("gaps2", {o_link_enable, o_symbol_gap, o_token_gap}, 23'h20_0C01);
    slow <= 1;
    wr(`ADDR_LINK_SETUP, 32'h0100_0000, 4'h8);
    rd(`ADDR_LINK_SETUP); chk("init", rd_d, 32'h0020_0C01);
    repeat (25) @(posedge i_clk_sys);
    rd(`ADDR_LINK_SETUP); chk("credit back", rd_d, 32'h0220_0C01);
    chk("greets", n_greet, 2);
    $display("link setup test done");
  endtask
  task automatic t_status();
    pulse(0, 1); rd(`ADDR_LINK_SETUP); chk("ovf", rd_d[27], 1);
    rd(`ADDR_LINK_SETUP); chk("err clr", rd_d[27], 0);
    pulse(1, 1); rd(`ADDR_LINK_SETUP); chk("illegal", rd_d[27], 1);
    wr(`ADDR_IRQ_MASK, 32'h0000_0001, 4'hF); repeat (3) @(posedge i_clk_sys);
    chk("irq on", o_irq, 1);
    wr(`ADDR_IRQ_STATUS, 32'h0000_0001, 4'hF); repeat (3) @(posedge i_clk_sys);
    chk("irq clr", o_irq, 0);
    wr(`ADDR_IRQ_MASK, 32'h0000_0000, 4'hF); pulse(0, 3);
    chk("irq mask", o_irq, 0);
    pulse(3, 1); rd(`ADDR_LINK_SETUP); chk("issued", rd_d[26], 1);
    pulse(4, 1); rd(`ADDR_LINK_SETUP); chk("withdrawn", rd_d[26], 0);
    pulse(2, 1); rd(`ADDR_LINK_SETUP); chk("used up", rd_d[25], 0);
    $display("status test done");
  endtask
  task automatic t_static();
    wr(`ADDR_STATIC_FWD, 32'hFFFF_FFFF, 4'hF);
    rd(`ADDR_STATIC_FWD); chk("static rd", rd_d, 32'h8000_001F);
    chk("static outs", {o_static_fwd, o_static_chanend}, 6'h3F);
    pulse(5, 2); chk("no junk", o_discard, 0);
    wr(`ADDR_STATIC_FWD, 32'h0000_0000, 4'hF); repeat (3) @(posedge i_clk_sys);
    pulse(5, 2); chk("junk", o_discard, 1);
    rd(`ADDR_PIN_OUT); chk("junk rd", rd_d[2], 1);
    pulse(6, 2); chk("junk end", o_discard, 0);
    wr(8'h10, 32'hFFFF_FFFF, 4'hF); chk("unmapped wr", resp, `RESP_SLVERR);
    rd(8'h10); chk("unmapped rd", rd_d, 32'h0000_0000);
    chk("unmapped rresp", resp, `RESP_SLVERR);
    $display("static test done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1;
    t_reset();
    t_link_cfg();
    t_status();
    t_static();
    close_out();
  end
endmodule
`default_nettype wire
